// ---- verilog/mps_pkg.sv ----
/*
  Constants for the multi-position sequencer: register map, field layout,
  reset values and timing figures.
  Assumes a 20 MHz system clock and 32-bit APB access.
*/
package mps_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned WAIT_UNIT_US = 1000;
  localparam int unsigned WAIT_UNIT_CYCLES = (CLK_HZ / 1_000_000) * WAIT_UNIT_US;

  // Table geometry
  localparam int unsigned ENTRY_COUNT = 16;
  localparam int unsigned IDX_W = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_WAIT = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_INT_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_INT_MASK = 12'h010;
  localparam logic [11:0] ADDR_POS_REF = 12'h014;
  localparam logic [11:0] ADDR_TABLE_BASE = 12'h100;
  localparam logic [3:0] TABLE_BASE_HI = 4'h1;
  localparam logic [1:0] TWORD_DISP = 2'h0;
  localparam logic [1:0] TWORD_SPEED = 2'h1;
  localparam logic [1:0] TWORD_RAMP = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // CTRL field positions
  localparam int unsigned CTRL_SRC_LSB = 0;
  localparam int unsigned CTRL_MODE_LSB = 2;
  localparam int unsigned CTRL_CMODE_LSB = 4;
  localparam int unsigned CTRL_FIRST_LSB = 8;
  localparam int unsigned CTRL_LAST_LSB = 12;
  localparam int unsigned CTRL_NOWAIT_BIT = 16;
  localparam int unsigned CTRL_OFFRAMP_BIT = 17;
  localparam int unsigned CTRL_POL_LSB = 20;
  localparam logic [31:0] CTRL_RESET = 32'h0000F000;
  localparam logic [31:0] CTRL_MASK = 32'h00F3FF3F;
  localparam logic [31:0] WAIT_RESET = 32'h00000000;

  // Field values
  localparam logic [1:0] SRC_MULTI = 2'h1;
  localparam logic [1:0] CMODE_POSITION = 2'h0;
  localparam logic [1:0] RUN_INDIVIDUAL = 2'h0;
  localparam logic [1:0] RUN_CYCLIC = 2'h1;
  localparam logic [1:0] RUN_DI_SELECT = 2'h2;

  // Interrupt bits
  localparam int unsigned INT_MOVE_DONE = 0;
  localparam int unsigned INT_CYCLE_DONE = 1;
  localparam int unsigned INT_STOP_DONE = 2;
  localparam int unsigned INT_W = 3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MOVE,
    ST_ABORT,
    ST_OFF_STOP,
    ST_WAIT
  } mps_state_type;

endpackage : mps_pkg

// ---- verilog/mps_profile.sv ----
/*
  Trapezoidal move generator: ramps speed toward a limit, decelerates
  symmetrically to end exactly on the distance, supports hold, ramped
  stop and immediate stop.
  Assumes inputs synchronous to clk_i; dist_i and vmax_i valid with start_i.
*/
`timescale 1ns/10ps
`default_nettype none
module mps_profile (
  input wire logic clk_i,          // System clock
  input wire logic sys_rst_i,      // Synchronous reset, active high
  input wire logic start_i,        // Begin a new move
  input wire logic [31:0] dist_i,  // Move distance magnitude
  input wire logic [15:0] vmax_i,  // Speed limit per cycle
  input wire logic [15:0] ramp_i,  // Cycles per speed unit change, less one
  input wire logic hold_i,         // Freeze planning
  input wire logic soft_stop_i,    // Ramp down and abandon
  input wire logic hard_stop_i,    // Stop at once
  output logic [15:0] step_o,      // Distance issued this cycle
  output logic busy_o,             // Move in progress
  output logic done_o              // One-cycle pulse at rest
);

  logic [31:0] remain_reg, remain_next;
  logic [31:0] accdist_reg, accdist_next;
  logic [15:0] speed_reg, speed_next;
  logic [15:0] ramp_cnt_reg, ramp_cnt_next;
  logic [15:0] step_next, vlim;
  logic stopping_reg, tick, decel, ends;

  assign vlim = (vmax_i == 16'h0000) ? 16'h0001 : vmax_i;
  assign busy_o = ~(remain_reg == 32'h00000000 && speed_reg == 16'h0000) | start_i;

  // Accelerate, cruise, then decelerate once remaining distance falls to or below ramp-up distance
  always_comb begin
    tick = (ramp_cnt_reg >= ramp_i);
    ramp_cnt_next = tick ? 16'h0000 : ramp_cnt_reg + 16'h0001;
    decel = stopping_reg || (remain_reg <= accdist_reg);
    speed_next = speed_reg;
    if (tick) begin
      if (decel) begin
        if (speed_reg > 16'h0001 || (stopping_reg && speed_reg != 16'h0000)) begin
          speed_next = speed_reg - 16'h0001;
        end
      end else if (speed_reg < vlim) begin
        speed_next = speed_reg + 16'h0001;
      end
    end
    if (!stopping_reg && speed_next == 16'h0000 && remain_reg != 32'h00000000) begin
      speed_next = 16'h0001;
    end
    step_next = ({16'h0000, speed_reg} > remain_reg) ? remain_reg[15:0] : speed_reg;
    remain_next = remain_reg - {16'h0000, step_next};
    accdist_next = (!decel && speed_reg < vlim) ? accdist_reg + {16'h0000, step_next}
                                                : accdist_reg;
    ends = stopping_reg ? (speed_reg == 16'h0000) : (remain_next == 32'h00000000);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || hard_stop_i) begin
      remain_reg <= 32'h00000000;
      accdist_reg <= 32'h00000000;
      speed_reg <= 16'h0000;
      ramp_cnt_reg <= 16'h0000;
      stopping_reg <= 1'b0;
      step_o <= 16'h0000;
      done_o <= hard_stop_i & ~sys_rst_i;
    end else if (start_i) begin
      remain_reg <= dist_i;
      accdist_reg <= 32'h00000000;
      speed_reg <= 16'h0000;
      ramp_cnt_reg <= 16'h0000;
      stopping_reg <= 1'b0;
      step_o <= 16'h0000;
      done_o <= (dist_i == 32'h00000000);
    end else if (busy_o && !hold_i) begin
      ramp_cnt_reg <= ramp_cnt_next;
      accdist_reg <= accdist_next;
      stopping_reg <= stopping_reg | soft_stop_i;
      step_o <= step_next;
      done_o <= ends;
      remain_reg <= (ends && stopping_reg) ? 32'h00000000 : remain_next;
      speed_reg <= ends ? 16'h0000 : speed_next;
    end else begin
      step_o <= 16'h0000;
      done_o <= 1'b0;
      stopping_reg <= stopping_reg & busy_o;
    end
  end

endmodule : mps_profile
`default_nettype wire

// ---- verilog/mps_sequencer.sv ----
/*
  Multi-position sequencer: 16-entry move table, run modes, wait timing,
  stop handling, in-position flag, APB register file and interrupt.
  Assumes APB master on clk_i, digital inputs already synchronous.
*/
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Sixteen entries: distance, speed, ramp each
// - Drive reference only when source selects multi
// - Programmable wait between moves, switch mode
// - Individual mode stops after one cycle
// - Advance to next entry automatically
// - Trigger is a level, held while running
// - In-position flag set at each target except a no-wait advance
// - Enable loss: abandon, stop, flag set
// - Energize loss while moving: configured stop, flag cleared
// - Pause input freezes planning
// - Cycle runs first to last group index
// - Cyclic mode restarts after each cycle
// - Cyclic repeats while trigger stays active
// - DI-select mode picks entry from inputs
// - Active only in position control mode
module mps_sequencer
  import mps_pkg::*;
#(
  parameter int unsigned WAIT_TICK_CYCLES = WAIT_UNIT_CYCLES
) (
  input wire logic clk_i,                 // System clock, 20 MHz
  input wire logic sys_rst_i,             // Synchronous reset, active high
  input wire logic psel_i,                // APB select
  input wire logic penable_i,             // APB enable
  input wire logic pwrite_i,              // APB write
  input wire logic [11:0] paddr_i,        // APB byte address
  input wire logic [31:0] pwdata_i,       // APB write data
  output logic [31:0] prdata_o,           // APB read data
  output logic pready_o,                  // APB ready
  output logic pslverr_o,                 // APB error on unmapped address
  input wire logic multi_enable_i,        // Multi-position enable, active high
  input wire logic motion_plan_trigger_i, // Planning trigger level
  input wire logic plan_pause_i,          // Planning pause level
  input wire logic energize_i,            // Drive energize command
  input wire logic [3:0] ref_select_i,    // ref_select_bit0..ref_select_bit3 raw
  output logic in_position_flag_o,        // Positioning complete
  output logic ref_valid_o,               // Reference owned by sequencer
  output logic [15:0] step_o,             // Signed-free step magnitude
  output logic step_dir_o,                // Step direction, 1 is negative
  output logic [31:0] pos_ref_o,          // Accumulated position reference
  output logic [IDX_W-1:0] entry_o,       // Active entry index
  output logic irq_o                      // Level interrupt
);

  if (WAIT_TICK_CYCLES < 1) begin : g_chk
    $error("WAIT_TICK_CYCLES must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and table
  logic [31:0] ctrl_reg;
  logic [31:0] wait_reg;
  logic [INT_W-1:0] int_status_reg, int_mask_reg, int_set;
  logic [31:0] disp_mem [ENTRY_COUNT];
  logic [15:0] speed_mem [ENTRY_COUNT];
  logic [15:0] ramp_mem [ENTRY_COUNT];

  logic [1:0] ref_source_select, multi_run_mode_select, control_mode_select;
  logic [IDX_W-1:0] first_group_index, last_group_index;
  logic [3:0] ref_select_pol;
  logic no_wait, off_ramp;

  assign ref_source_select = ctrl_reg[CTRL_SRC_LSB +: 2];
  assign multi_run_mode_select = ctrl_reg[CTRL_MODE_LSB +: 2];
  assign control_mode_select = ctrl_reg[CTRL_CMODE_LSB +: 2];
  assign first_group_index = ctrl_reg[CTRL_FIRST_LSB +: IDX_W];
  assign last_group_index = ctrl_reg[CTRL_LAST_LSB +: IDX_W];
  assign no_wait = ctrl_reg[CTRL_NOWAIT_BIT];
  assign off_ramp = ctrl_reg[CTRL_OFFRAMP_BIT];
  assign ref_select_pol = ctrl_reg[CTRL_POL_LSB +: 4];

  logic apb_acc, apb_wr, apb_rd, tbl_hit, addr_ok;
  logic [IDX_W-1:0] tbl_idx;
  logic [1:0] tbl_word;

  assign apb_acc = psel_i & penable_i;
  assign apb_wr = apb_acc & pwrite_i;
  assign apb_rd = apb_acc & ~pwrite_i;
  assign tbl_hit = (paddr_i[11:8] == TABLE_BASE_HI) && (paddr_i[3:2] != 2'h3);
  assign tbl_idx = paddr_i[7:4];
  assign tbl_word = paddr_i[3:2];
  assign pready_o = 1'b1;

  always_comb begin
    addr_ok = tbl_hit && (paddr_i[1:0] == 2'h0);
    case (paddr_i)
      ADDR_CTRL, ADDR_WAIT, ADDR_STATUS, ADDR_INT_STATUS,
      ADDR_INT_MASK, ADDR_POS_REF: addr_ok = 1'b1;
      default: ;
    endcase
  end
  assign pslverr_o = apb_acc & ~addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  mps_state_type state_reg, state_next;
  logic [IDX_W-1:0] idx_reg, idx_next;
  logic in_pos_reg, rearm_reg, dir_reg;
  logic [31:0] pos_reg;
  logic [31:0] tick_cnt_reg;
  logic [15:0] wait_cnt_reg;
  logic op_active, go, prof_start, soft_stop, hard_stop;
  logic prof_busy, prof_done, wait_done;
  logic adv_start, adv_rearm, adv_cycle;
  mps_state_type adv_state;
  logic [IDX_W-1:0] adv_idx, di_idx, start_idx;
  logic [15:0] prof_step;
  logic [31:0] sel_disp, dist_mag;

  assign op_active = (ref_source_select == SRC_MULTI)
                   && (control_mode_select == CMODE_POSITION);
  assign go = op_active && multi_enable_i && energize_i
            && motion_plan_trigger_i;
  assign di_idx = ref_select_i ^ ref_select_pol;

  // Where to go when one move and its wait are over
  always_comb begin
    adv_state = ST_IDLE;
    adv_idx = idx_reg;
    adv_start = 1'b0;
    adv_rearm = 1'b0;
    adv_cycle = 1'b0;
    if (multi_run_mode_select == RUN_DI_SELECT) begin
      adv_rearm = 1'b1;
    end else if (idx_reg == last_group_index) begin
      adv_cycle = 1'b1;
      if (multi_run_mode_select == RUN_CYCLIC && go) begin
        adv_state = ST_MOVE;
        adv_idx = first_group_index;
        adv_start = 1'b1;
      end else begin
        adv_rearm = (multi_run_mode_select == RUN_INDIVIDUAL);
      end
    end else if (go) begin
      adv_state = ST_MOVE;
      adv_idx = idx_reg + 4'h1;
      adv_start = 1'b1;
    end
  end

  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    prof_start = 1'b0;
    soft_stop = 1'b0;
    hard_stop = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (go && !rearm_reg) begin
          state_next = ST_MOVE;
          idx_next = (multi_run_mode_select == RUN_DI_SELECT) ? di_idx
                                                              : first_group_index;
          prof_start = 1'b1;
        end
      end
      ST_MOVE: begin
        if (!energize_i) begin
          state_next = ST_OFF_STOP;
          soft_stop = off_ramp;
          hard_stop = ~off_ramp;
        end else if (!multi_enable_i || !op_active) begin
          state_next = ST_ABORT;
          soft_stop = 1'b1;
        end else if (prof_done) begin
          if (no_wait) begin
            state_next = adv_state;
            idx_next = adv_idx;
            prof_start = adv_start;
          end else begin
            state_next = ST_WAIT;
          end
        end
      end
      ST_ABORT: begin
        // Held so a stop requested while paused is not lost
        soft_stop = 1'b1;
        if (!energize_i) begin
          hard_stop = ~off_ramp;
          state_next = ST_OFF_STOP;
        end else if (!prof_busy) begin
          state_next = ST_IDLE;
        end
      end
      ST_OFF_STOP: begin
        soft_stop = off_ramp;
        if (!prof_busy) begin
          state_next = ST_IDLE;
        end
      end
      ST_WAIT: begin
        if (!energize_i || !multi_enable_i || !op_active) begin
          state_next = ST_IDLE;
        end else if (wait_done) begin
          state_next = adv_state;
          idx_next = adv_idx;
          prof_start = adv_start;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_IDLE;
      idx_reg <= 4'h0;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Move profile
  assign start_idx = idx_next;
  assign sel_disp = disp_mem[start_idx];
  assign dist_mag = sel_disp[31] ? (32'h00000000 - sel_disp) : sel_disp;

  mps_profile u_profile (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(prof_start),
    .dist_i(dist_mag),
    .vmax_i(speed_mem[start_idx]),
    .ramp_i(ramp_mem[start_idx]),
    .hold_i(plan_pause_i),
    .soft_stop_i(soft_stop),
    .hard_stop_i(hard_stop),
    .step_o(prof_step),
    .busy_o(prof_busy),
    .done_o(prof_done)
  );

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dir_reg <= 1'b0;
      pos_reg <= 32'h00000000;
    end else begin
      if (prof_start) begin
        dir_reg <= sel_disp[31];
      end
      if (dir_reg) begin
        pos_reg <= pos_reg - {16'h0000, prof_step};
      end else begin
        pos_reg <= pos_reg + {16'h0000, prof_step};
      end
    end
  end

  assign step_o = prof_step;
  assign step_dir_o = dir_reg;
  assign pos_ref_o = pos_reg;
  assign entry_o = idx_reg;
  assign ref_valid_o = op_active;

  ////////////////////////////////////////////////////////////////////////////
  // Wait timer, frozen by pause
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || state_reg != ST_WAIT) begin
      tick_cnt_reg <= 32'h00000000;
      wait_cnt_reg <= 16'h0000;
    end else if (!plan_pause_i && !wait_done) begin
      if (tick_cnt_reg >= WAIT_TICK_CYCLES - 1) begin
        tick_cnt_reg <= 32'h00000000;
        wait_cnt_reg <= wait_cnt_reg + 16'h0001;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      end
    end
  end
  assign wait_done = (wait_cnt_reg >= wait_reg[15:0]) && !plan_pause_i;

  ////////////////////////////////////////////////////////////////////////////
  // In-position flag and rearm latch
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      in_pos_reg <= 1'b0;
    end else if (prof_start) begin
      in_pos_reg <= 1'b0;
    end else if (state_reg == ST_MOVE && prof_done && energize_i && multi_enable_i) begin
      in_pos_reg <= 1'b1;
    end else if (state_reg == ST_ABORT && !prof_busy) begin
      in_pos_reg <= 1'b1;
    end else if (state_reg == ST_OFF_STOP && !prof_busy) begin
      in_pos_reg <= 1'b0;
    end
  end
  assign in_position_flag_o = in_pos_reg;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !motion_plan_trigger_i) begin
      rearm_reg <= 1'b0;
    end else if ((state_reg == ST_MOVE && prof_done && no_wait) ||
                 (state_reg == ST_WAIT && wait_done)) begin
      rearm_reg <= rearm_reg | adv_rearm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, table and interrupts
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_reg <= CTRL_RESET;
      wait_reg <= WAIT_RESET;
      int_mask_reg <= '0;
    end else if (apb_wr) begin
      case (paddr_i)
        ADDR_CTRL: ctrl_reg <= pwdata_i & CTRL_MASK;
        ADDR_WAIT: wait_reg <= {16'h0000, pwdata_i[15:0]};
        ADDR_INT_MASK: int_mask_reg <= pwdata_i[INT_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < ENTRY_COUNT; i++) begin
        disp_mem[i] <= 32'h00000000;
        speed_mem[i] <= 16'h0000;
        ramp_mem[i] <= 16'h0000;
      end
    end else if (apb_wr && addr_ok && tbl_hit) begin
      case (tbl_word)
        TWORD_DISP: disp_mem[tbl_idx] <= pwdata_i;
        TWORD_SPEED: speed_mem[tbl_idx] <= pwdata_i[15:0];
        TWORD_RAMP: ramp_mem[tbl_idx] <= pwdata_i[15:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    int_set = '0;
    int_set[INT_MOVE_DONE] = (state_reg == ST_MOVE) && prof_done && energize_i;
    int_set[INT_CYCLE_DONE] = ((state_reg == ST_MOVE && prof_done && no_wait) ||
                               (state_reg == ST_WAIT && wait_done)) && adv_cycle;
    int_set[INT_STOP_DONE] = (state_reg == ST_ABORT || state_reg == ST_OFF_STOP)
                           && !prof_busy;
  end

  // Read clears, a same-cycle event survives
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      int_status_reg <= '0;
    end else if (apb_rd && paddr_i == ADDR_INT_STATUS) begin
      int_status_reg <= int_set;
    end else begin
      int_status_reg <= int_status_reg | int_set;
    end
  end
  assign irq_o = |(int_status_reg & int_mask_reg);

  always_comb begin
    prdata_o = 32'h00000000;
    if (tbl_hit) begin
      case (tbl_word)
        TWORD_DISP: prdata_o = disp_mem[tbl_idx];
        TWORD_SPEED: prdata_o = {16'h0000, speed_mem[tbl_idx]};
        TWORD_RAMP: prdata_o = {16'h0000, ramp_mem[tbl_idx]};
        default: ;
      endcase
    end else begin
      case (paddr_i)
        ADDR_CTRL: prdata_o = ctrl_reg;
        ADDR_WAIT: prdata_o = wait_reg;
        ADDR_STATUS: prdata_o = {20'h00000, op_active, 3'h0, idx_reg,
                                 1'b0, prof_busy, state_reg != ST_IDLE, in_pos_reg};
        ADDR_INT_STATUS: prdata_o = {29'h00000000, int_status_reg};
        ADDR_INT_MASK: prdata_o = {29'h00000000, int_mask_reg};
        ADDR_POS_REF: prdata_o = pos_reg;
        default: ;
      endcase
    end
  end

endmodule : mps_sequencer
`default_nettype wire

// ---- dv/mps_host_model.sv ----
/* Host controller model: drives the sequencer's digital control inputs.
   Assumes bench commands change just after rising edges of clk_i. */
`timescale 1ns/10ps
`default_nettype none
module mps_host_model (
  input wire logic clk_i,         // Clock
  input wire logic sys_rst_i,     // Reset, active high
  input wire logic [3:0] cmd_i,   // Energize, pause, trigger, enable
  input wire logic [3:0] sel_i,   // Entry select levels
  output logic multi_enable_o,    // Enable level
  output logic trigger_o,         // Plan trigger level
  output logic pause_o,           // Plan pause level
  output logic energize_o,        // Energize level
  output logic [3:0] ref_select_o // Entry select
);
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      {energize_o, pause_o, trigger_o, multi_enable_o} <= 4'h0;
      ref_select_o <= 4'h0;
    end else begin
      {energize_o, pause_o, trigger_o, multi_enable_o} <= cmd_i;
      ref_select_o <= sel_i;
    end
  end
endmodule : mps_host_model
`default_nettype wire

// ---- dv/mps_sequencer_chk.sv ----
/* Checker for the multi-position sequencer, bound to its top module.
   Assumes one clock domain with synchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module mps_sequencer_chk
  import mps_pkg::*;
#(
  parameter int unsigned WAIT_TICK_CYCLES = 4
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic plan_pause_i,
  input wire logic motion_plan_trigger_i,
  input wire logic energize_i,
  input wire logic in_position_flag_o,
  input wire logic ref_valid_o,
  input wire logic pslverr_o,
  input wire logic [15:0] step_o,
  input wire logic [31:0] pos_ref_o,
  input wire logic [IDX_W-1:0] entry_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_pause_freeze: assert property ($past(plan_pause_i) |-> step_o == 16'h0)
    else $error("step issued while paused");
  a_flag_at_rest: assert property (in_position_flag_o |-> step_o == 16'h0)
    else $error("in-position while moving");
  a_start_slow: assert property ($past(step_o) == 16'h0 && step_o != 16'h0
    && !$past(plan_pause_i) && !$past(plan_pause_i, 2) |-> step_o == 16'h1)
    else $error("move did not start at lowest speed");
  a_entry_hold: assert property (step_o != 16'h0 |-> $stable(entry_o))
    else $error("entry changed mid-move");
  a_pos_rest: assert property ($past(step_o) == 16'h0 && step_o == 16'h0
    |-> $stable(pos_ref_o))
    else $error("position moved without steps");
  a_flag_drop: assert property ($fell(in_position_flag_o)
    |-> !$past(energize_i) || $past(motion_plan_trigger_i))
    else $error("in-position dropped without cause");
  a_src_write: assert property ($changed(ref_valid_o)
    |-> $past(psel_i && penable_i && pwrite_i))
    else $error("reference ownership changed without write");
  a_err_phase: assert property (!(psel_i && penable_i) |-> !pslverr_o)
    else $error("bus error outside access phase");
endmodule : mps_sequencer_chk
bind mps_sequencer mps_sequencer_chk #(.WAIT_TICK_CYCLES(WAIT_TICK_CYCLES)) i_chk (
  .clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .plan_pause_i, .motion_plan_trigger_i,
  .energize_i, .in_position_flag_o, .ref_valid_o, .pslverr_o, .step_o, .pos_ref_o, .entry_o);
`default_nettype wire

// ---- dv/testbench.sv ----
/* Self-checking bench for the multi-position sequencer.
   Assumes zero-wait APB slave and the host model on the control inputs. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import mps_pkg::*;
  logic clk_i = 0, sys_rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0, err;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, rd, d0, d1, p0, prdata_o, pos_ref_o;
  logic [3:0] cmd = 0, sel = 0, rsel, entry_o;
  logic [15:0] step_o;
  logic pready_o, pslverr_o, en, trg, pau, enr, in_position_flag_o, ref_valid_o, step_dir_o, irq_o;
  int fails = 0, n_checks = 0, cyc = 0, k;
  always #25 clk_i = ~clk_i;
  mps_host_model i_host (.clk_i, .sys_rst_i, .cmd_i(cmd), .sel_i(sel), .multi_enable_o(en),
    .trigger_o(trg), .pause_o(pau), .energize_o(enr), .ref_select_o(rsel));
  mps_sequencer #(.WAIT_TICK_CYCLES(4)) i_dut (.clk_i, .sys_rst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .multi_enable_i(en),
    .motion_plan_trigger_i(trg), .plan_pause_i(pau), .energize_i(enr), .ref_select_i(rsel),
    .in_position_flag_o, .ref_valid_o, .step_o, .step_dir_o, .pos_ref_o, .entry_o, .irq_o);
  task automatic complete_run;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic host(input logic [3:0] c);
    @(posedge clk_i);
    cmd <= c;
  endtask : host
  task automatic wait_flag(input logic v);
    for (k = 0; k < 3000 && in_position_flag_o !== v; k++) @(negedge clk_i);
    chk(in_position_flag_o === v, "in-position wait");
  endtask : wait_flag
  task automatic wait_step;
    for (k = 0; k < 3000 && step_o === 16'h0; k++) @(negedge clk_i);
  endtask : wait_step
  function automatic logic [31:0] ctrl(input logic [1:0] mode);
    return {16'h0, 4'h1, 4'h0, 2'h0, CMODE_POSITION, mode, SRC_MULTI};
  endfunction : ctrl
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    k = $urandom(32'hB643);
    d0 = 32'($urandom_range(15, 1));
    d1 = 32'($urandom_range(15, 1));
    sel = 4'($urandom);
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    chk(in_position_flag_o === 1'b0 && irq_o === 1'b0 && ref_valid_o === 1'b0, "reset outputs");
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd === CTRL_RESET, "control reset value");
    apb(1'b0, 12'h10C, 32'h0);
    chk(err === 1'b1, "unmapped access not refused");
    apb(1'b1, ADDR_TABLE_BASE, d0);
    apb(1'b1, 12'h104, 32'($urandom_range(3, 1)));
    apb(1'b1, 12'h110, d1);
    apb(1'b1, 12'h114, 32'h2);
    apb(1'b1, 12'h118, 32'h1);
    apb(1'b1, ADDR_WAIT, 32'h1);
    apb(1'b1, ADDR_CTRL, ctrl(RUN_INDIVIDUAL));
    @(negedge clk_i);
    chk(ref_valid_o === 1'b1, "reference not owned");
    host(4'hB);
    wait_flag(1'b1);
    wait_flag(1'b0);
    wait_flag(1'b1);
    repeat (40) @(negedge clk_i);
    chk(pos_ref_o === d0 + d1 && entry_o === 4'h1, "single cycle");
    apb(1'b1, ADDR_INT_MASK, 32'h2);
    @(negedge clk_i);
    chk(irq_o === 1'b1, "interrupt not raised");
    apb(1'b0, ADDR_INT_STATUS, 32'h0);
    chk(rd[2:0] === 3'h3, "event bits");
    @(negedge clk_i);
    chk(irq_o === 1'b0, "interrupt not cleared");
    host(4'h9);
    apb(1'b1, ADDR_CTRL, ctrl(RUN_CYCLIC));
    p0 = pos_ref_o;
    host(4'hF);
    repeat (30) @(negedge clk_i);
    chk(pos_ref_o === p0, "moved while paused");
    host(4'hB);
    for (k = 0; k < 5000 && pos_ref_o !== p0 + 2 * (d0 + d1); k++) @(negedge clk_i);
    chk(pos_ref_o === p0 + 2 * (d0 + d1), "cyclic repeat");
    // Long first move so that both stops land in mid-move
    host(4'h9);
    repeat (100) @(negedge clk_i);
    apb(1'b1, ADDR_TABLE_BASE, 32'h400);
    p0 = pos_ref_o;
    host(4'hB);
    wait_step();
    host(4'hA);
    wait_flag(1'b1);
    chk(pos_ref_o - p0 < 32'h400, "abandoned move completed");
    host(4'h8);
    p0 = pos_ref_o;
    host(4'hB);
    wait_step();
    host(4'h3);
    repeat (200) @(negedge clk_i);
    chk(in_position_flag_o === 1'b0 && step_o === 16'h0, "energize stop");
    chk(pos_ref_o - p0 < 32'h400, "move not stopped on energize loss");
    host(4'h9);
    apb(1'b1, ADDR_CTRL, ctrl(RUN_DI_SELECT) | 32'h00F00000);
    host(4'hB);
    wait_flag(1'b1);
    chk(entry_o === ~sel, "input-selected entry");
    complete_run();
  end
endmodule : testbench
`default_nettype wire
